// ==== core/ccp_host.v ====
// Purpose: bus controller driving the clock generator's config port
// Assumes: one pending request at a time; single controller on the bus
// Notes:   retries the whole frame after a refused address, up to RETRY_MAX times, then ends with error_o set
//
// Operation
// - Write frame: address+0, command xx00, pointer, data; all acked.
// - Before a non-sequential read, send pointer-only write frame.
// - After pointer frame, use repeated START straight into read.
// - Read frame: identification byte first, then data; NACK the last.
// - Save or restore: address byte plus command byte, then STOP.
// - Treat the bus as busy while save or restore runs.
// - Ready only when address is acknowledged; retry on NACK.
// - Every frame opens with START and closes with STOP.
// - First byte: 7-bit target address then direction bit.
// - Acknowledge is data low; not-acknowledge is data high.
// - Repeated START may replace STOP to keep the bus.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_regs.vh"
module ccp_host #(
  parameter [7:0] RETRY_MAX = `CCP_RETRY_MAX
) (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       req_valid_i,
  input  wire [1:0] req_kind_i,
  input  wire [7:0] req_ptr_i,
  input  wire       req_set_ptr_i,
  input  wire [7:0] req_len_i,
  input  wire       wr_valid_i,
  input  wire [7:0] wr_data_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       req_ready_o,
  output wire       wr_ready_o,
  output reg        rd_valid_o,
  output reg  [7:0] rd_data_o,
  output reg        rd_id_o,
  output reg        busy_o,
  output reg        done_o,
  output reg        error_o,
  output wire       scl_o,
  output wire       scl_oe_o,
  output wire       sda_o,
  output wire       sda_oe_o
);
  // request kinds
  localparam [1:0] K_WRITE   = 2'h0;
  localparam [1:0] K_READ    = 2'h1;
  localparam [1:0] K_SAVE    = 2'h2;
  localparam [1:0] K_RESTORE = 2'h3;
  localparam [1:0] OP_START = 2'h0;
  localparam [1:0] OP_STOP  = 2'h1;
  localparam [1:0] OP_BYTE  = 2'h2;
  localparam [3:0] H_IDLE  = 4'h0;
  localparam [3:0] H_START = 4'h1;
  localparam [3:0] H_ADDR  = 4'h2;
  localparam [3:0] H_CMD   = 4'h3;
  localparam [3:0] H_PTR   = 4'h4;
  localparam [3:0] H_WDATA = 4'h5;
  localparam [3:0] H_RSTA  = 4'h6;
  localparam [3:0] H_RADDR = 4'h7;
  localparam [3:0] H_RDATA = 4'h8;
  localparam [3:0] H_STOP  = 4'h9;
  localparam [3:0] H_BUF   = 4'ha;
  localparam [3:0] H_WAIT  = 4'hb;
  localparam [31:0] TBUF_W = `CCP_TBUF_CYC;
  localparam [7:0]  TBUF   = TBUF_W[7:0];

  reg  [3:0] state_reg;
  reg  [3:0] after_stop_reg;
  reg  [1:0] kind_reg;
  reg  [7:0] ptr_reg;
  reg        set_ptr_reg;
  reg  [7:0] left_reg;
  reg  [7:0] retry_reg;
  reg  [7:0] buf_reg;
  reg        first_rd_reg;
  reg        issued_reg;
  reg        fail_reg;
  reg  [1:0] op_reg;
  reg  [7:0] tx_reg;
  reg        tx_ack_reg;
  reg        op_valid_reg;
  wire       op_ready;
  wire       op_done;
  wire [7:0] rx_byte;
  wire       rx_ack;

  function [7:0] addr_byte;
    input dir;
    begin
      addr_byte = {`CCP_TARGET_ADDR, dir};
    end
  endfunction

  function [7:0] cmd_byte;
    input [1:0] kind;
    begin
      // low bits select write, save or restore; 11 never sent
      case (kind)
        K_SAVE:    cmd_byte = {6'h00, `CCP_CMD_SAVE};
        K_RESTORE: cmd_byte = {6'h00, `CCP_CMD_RESTORE};
        default:   cmd_byte = {6'h00, `CCP_CMD_WRITE};
      endcase
    end
  endfunction

  assign req_ready_o = (state_reg == H_IDLE);
  assign wr_ready_o  = (state_reg == H_WDATA) && issued_reg && op_done;

  ccp_bit_engine u_bits (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .op_i       (op_reg),
    .op_valid_i (op_valid_reg),
    .tx_byte_i  (tx_reg),
    .tx_ack_i   (tx_ack_reg),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .op_ready_o (op_ready),
    .done_o     (op_done),
    .rx_byte_o  (rx_byte),
    .rx_ack_o   (rx_ack),
    .scl_o      (scl_o),
    .scl_oe_o   (scl_oe_o),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o)
  );

  always @(posedge ref_clk_i) begin
    op_valid_reg <= 1'b0;
    rd_valid_o   <= 1'b0;
    done_o       <= 1'b0;
    if (reset_i) begin
      state_reg      <= H_IDLE;
      after_stop_reg <= H_IDLE;
      kind_reg       <= K_WRITE;
      ptr_reg        <= 8'h00;
      set_ptr_reg    <= 1'b0;
      left_reg       <= 8'h00;
      retry_reg      <= 8'h00;
      buf_reg        <= 8'h00;
      first_rd_reg   <= 1'b0;
      issued_reg     <= 1'b0;
      fail_reg       <= 1'b0;
      op_reg         <= OP_START;
      tx_reg         <= 8'hff;
      tx_ack_reg     <= 1'b1;
      rd_data_o      <= 8'h00;
      rd_id_o        <= 1'b0;
      busy_o         <= 1'b0;
      error_o        <= 1'b0;
    end else if (state_reg == H_IDLE) begin
      busy_o <= 1'b0;
      if (req_valid_i) begin
        kind_reg    <= req_kind_i;
        ptr_reg     <= req_ptr_i;
        set_ptr_reg <= req_set_ptr_i;
        left_reg    <= req_len_i;
        retry_reg   <= RETRY_MAX;
        fail_reg    <= 1'b0;
        error_o     <= 1'b0;
        busy_o      <= 1'b1;
        issued_reg  <= 1'b0;
        // reads without pointer load continue from the last register
        state_reg   <= (req_kind_i == K_READ && !req_set_ptr_i) ?
                       H_RSTA : H_START;
      end
    end else if (state_reg == H_BUF) begin
      // bus free time between stop and the next start
      if (buf_reg != 8'h00) begin
        buf_reg <= buf_reg - 8'h01;
      end else begin
        issued_reg <= 1'b0;
        busy_o     <= (after_stop_reg != H_IDLE);
        state_reg  <= after_stop_reg;
      end
    end else if (state_reg == H_WAIT) begin
      // retry the whole frame after a refused address
      retry_reg  <= retry_reg - 8'h01;
      issued_reg <= 1'b0;
      state_reg  <= (kind_reg == K_READ && !set_ptr_reg) ? H_RSTA : H_START;
    end else if (!issued_reg) begin
      // launch the bus operation of this state
      if (op_ready && !op_valid_reg) begin
        issued_reg   <= 1'b1;
        op_valid_reg <= 1'b1;
        tx_ack_reg   <= 1'b1;
        op_reg       <= OP_BYTE;
        case (state_reg)
          H_START, H_RSTA: op_reg <= OP_START;
          H_STOP:          op_reg <= OP_STOP;
          H_ADDR:  tx_reg <= addr_byte(`CCP_DIR_WRITE);
          H_RADDR: tx_reg <= addr_byte(`CCP_DIR_READ);
          H_CMD:   tx_reg <= cmd_byte(kind_reg);
          H_PTR:   tx_reg <= ptr_reg;
          H_WDATA: tx_reg <= wr_data_i;
          H_RDATA: begin
            tx_reg     <= 8'hff;
            // acknowledge all but the last byte
            tx_ack_reg <= (left_reg == {7'h00, !first_rd_reg});
          end
          default: op_reg <= OP_STOP;
        endcase
        if (state_reg == H_WDATA && !wr_valid_i) begin
          issued_reg   <= 1'b0;
          op_valid_reg <= 1'b0;
        end
      end
    end else if (op_done) begin
      issued_reg <= 1'b0;
      case (state_reg)
        H_START: state_reg <= H_ADDR;
        H_RSTA:  state_reg <= H_RADDR;
        H_ADDR, H_RADDR: begin
          if (rx_ack) begin
            // no acknowledge: target busy or absent; stop, then retry unless retry_reg is zero
            after_stop_reg <= (retry_reg == 8'h00) ? H_IDLE : H_WAIT;
            fail_reg       <= (retry_reg == 8'h00);
            state_reg      <= H_STOP;
          end else if (state_reg == H_RADDR) begin
            first_rd_reg <= 1'b1;
            state_reg    <= H_RDATA;
          end else begin
            state_reg <= H_CMD;
          end
        end
        H_CMD: begin
          if (kind_reg == K_SAVE || kind_reg == K_RESTORE) begin
            after_stop_reg <= H_IDLE;
            state_reg      <= H_STOP;
          end else begin
            state_reg <= H_PTR;
          end
        end
        H_PTR: begin
          if (kind_reg == K_READ)
            state_reg <= H_RSTA;
          else if (left_reg == 8'h00) begin
            after_stop_reg <= H_IDLE;
            state_reg      <= H_STOP;
          end else
            state_reg <= H_WDATA;
        end
        H_WDATA: begin
          left_reg <= left_reg - 8'h01;
          if (left_reg == 8'h01 || rx_ack) begin
            fail_reg       <= rx_ack;
            after_stop_reg <= H_IDLE;
            state_reg      <= H_STOP;
          end
        end
        H_RDATA: begin
          rd_valid_o   <= 1'b1;
          rd_data_o    <= rx_byte;
          rd_id_o      <= first_rd_reg;
          first_rd_reg <= 1'b0;
          if (!first_rd_reg)
            left_reg <= left_reg - 8'h01;
          if ((!first_rd_reg && left_reg == 8'h01) ||
              (first_rd_reg && left_reg == 8'h00)) begin
            after_stop_reg <= H_IDLE;
            state_reg      <= H_STOP;
          end
        end
        H_STOP: begin
          buf_reg   <= TBUF;
          state_reg <= H_BUF;
          if (after_stop_reg == H_IDLE) begin
            done_o  <= 1'b1;
            error_o <= fail_reg;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/ccp_regs.vh ====
// Purpose: constants for the clock-generator config-port bus controller
// Assumes: 40 MHz system clock
// Notes:   timing counts derived from fast-mode figures in ns
`ifndef CCP_REGS_VH
`define CCP_REGS_VH
`define CCP_CLK_NS        25
`define CCP_TLOW_NS       1300
`define CCP_THIGH_NS      600
`define CCP_TBUF_NS       1300
`define CCP_TLOW_CYC      ((`CCP_TLOW_NS + `CCP_CLK_NS - 1) / `CCP_CLK_NS)
`define CCP_THIGH_CYC     ((`CCP_THIGH_NS + `CCP_CLK_NS - 1) / `CCP_CLK_NS)
`define CCP_TBUF_CYC      ((`CCP_TBUF_NS + `CCP_CLK_NS - 1) / `CCP_CLK_NS)
`define CCP_TARGET_ADDR   7'h6a
`define CCP_CMD_WRITE     2'h0
`define CCP_CMD_SAVE      2'h1
`define CCP_CMD_RESTORE   2'h2
`define CCP_DIR_WRITE     1'b0
`define CCP_DIR_READ      1'b1
`define CCP_RETRY_MAX     8'hff
`endif

// ==== core/ccp_bit_engine.v ====
// Purpose: bit-level engine: start, stop, one byte plus acknowledge
// Assumes: open-drain lines, enable high pulls the line low
// Notes:   samples both lines through two flip-flops; waits on stretch
`timescale 1ns/1ps
`default_nettype none
`include "ccp_regs.vh"
module ccp_bit_engine (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire [1:0] op_i,
  input  wire       op_valid_i,
  input  wire [7:0] tx_byte_i,
  input  wire       tx_ack_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       op_ready_o,
  output reg        done_o,
  output reg  [7:0] rx_byte_o,
  output reg        rx_ack_o,
  output wire       scl_o,
  output wire       scl_oe_o,
  output wire       sda_o,
  output wire       sda_oe_o
);
  localparam [1:0] OP_START = 2'h0;
  localparam [1:0] OP_STOP  = 2'h1;
  localparam [1:0] OP_BYTE  = 2'h2;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LOW  = 3'h1;
  localparam [2:0] S_RISE = 3'h2;
  localparam [2:0] S_HIGH = 3'h3;
  localparam [2:0] S_STA  = 3'h4;
  localparam [2:0] S_STO  = 3'h5;
  localparam [31:0] TLOW_W  = `CCP_TLOW_CYC;
  localparam [31:0] THIGH_W = `CCP_THIGH_CYC;
  localparam [7:0]  TLOW    = TLOW_W[7:0];
  localparam [7:0]  THIGH   = THIGH_W[7:0];
  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [8:0] sh_reg;
  reg [1:0] op_reg;
  reg       scl_low_reg;
  reg       sda_low_reg;
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  wire      scl_s = scl_sync_reg[1];
  wire      sda_s = sda_sync_reg[1];
  assign op_ready_o = (state_reg == S_IDLE);
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_low_reg;
  assign sda_oe_o = sda_low_reg;
  always @(posedge ref_clk_i) begin
    scl_sync_reg <= {scl_sync_reg[0], scl_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
    done_o <= 1'b0;
    if (reset_i) begin
      state_reg   <= S_IDLE;
      cnt_reg     <= 8'h00;
      bit_reg     <= 4'h0;
      sh_reg      <= 9'h1ff;
      op_reg      <= OP_START;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      rx_byte_o   <= 8'h00;
      rx_ack_o    <= 1'b1;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (op_valid_i) begin
            op_reg  <= op_i;
            cnt_reg <= TLOW;
            bit_reg <= 4'h0;
            sh_reg  <= {tx_byte_i, tx_ack_i};
            if (op_i == OP_BYTE) begin
              scl_low_reg <= 1'b1;
              state_reg   <= S_LOW;
            end else if (op_i == OP_START) begin
              // release both (repeated start case) then pull data low
              sda_low_reg <= 1'b0;
              state_reg   <= S_LOW;
            end else begin
              sda_low_reg <= 1'b1;
              state_reg   <= S_LOW;
            end
          end
        end
        S_LOW: begin
          if (op_reg == OP_BYTE && cnt_reg == TLOW)
            sda_low_reg <= ~sh_reg[8];
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            scl_low_reg <= 1'b0;
            state_reg   <= S_RISE;
          end
        end
        S_RISE: begin
          if (scl_s) begin
            cnt_reg   <= THIGH;
            state_reg <= (op_reg == OP_BYTE) ? S_HIGH :
                         (op_reg == OP_START) ? S_STA : S_STO;
          end
        end
        S_HIGH: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            sh_reg      <= {sh_reg[7:0], sda_s};
            scl_low_reg <= 1'b1;
            cnt_reg     <= TLOW;
            if (bit_reg == 4'h8) begin
              rx_byte_o   <= sh_reg[7:0];
              rx_ack_o    <= sda_s;
              // data held past the clock fall; next op moves it
              done_o      <= 1'b1;
              state_reg   <= S_IDLE;
            end else begin
              bit_reg   <= bit_reg + 4'h1;
              state_reg <= S_LOW;
            end
          end
        end
        S_STA: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (!sda_low_reg) begin
            sda_low_reg <= 1'b1;
            cnt_reg     <= THIGH;
          end else begin
            scl_low_reg <= 1'b1;
            done_o      <= 1'b1;
            state_reg   <= S_IDLE;
          end
        end
        S_STO: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            sda_low_reg <= 1'b0;
            done_o      <= 1'b1;
            state_reg   <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/ccp_host_monitor.sv ====
// Purpose: port checker for the config-port bus controller
// Assumes: one clock domain, sync active-high reset
// Notes:   bound to every ccp_host instance
`timescale 1ns/1ps
`default_nettype none
module ccp_host_monitor (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic rd_valid_o,
  input wire logic wr_ready_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence take_s; req_valid_i && req_ready_o; endsequence
  sequence start_s; !scl_oe_o && $rose(sda_oe_o); endsequence
  after_reset_a: assert property ($fell(reset_i) |->
    !scl_oe_o && !sda_oe_o && req_ready_o) else $error("not idle");
  pins_low_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  take_busy_a: assert property (take_s |=> busy_o)
    else $error("busy missing after take");
  take_start_a: assert property (take_s |-> ##[1:300] start_s)
    else $error("no start after take");
  done_released_a: assert property (done_o |->
    !scl_oe_o && !sda_oe_o) else $error("lines held at done");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  busy_refuse_a: assert property (busy_o |-> !req_ready_o)
    else $error("ready while busy");
  idle_quiet_a: assert property (!busy_o |->
    !scl_oe_o && !sda_oe_o) else $error("bus driven while idle");
  scl_low_a: assert property ($rose(scl_oe_o) |=> scl_oe_o [*8])
    else $error("clock low too short");
  scl_high_a: assert property ($fell(scl_oe_o) |=> !scl_oe_o [*8])
    else $error("clock high too short");
  data_in_frame_a: assert property (rd_valid_o || wr_ready_o
    |-> busy_o) else $error("data strobe outside frame");
endmodule
bind ccp_host ccp_host_monitor u_ccp_host_monitor (.ref_clk_i, .reset_i,
  .req_valid_i, .req_ready_o, .rd_valid_o, .wr_ready_o, .busy_o,
  .done_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
`default_nettype wire

// ==== tb/ccp_dev_model.sv ====
// Purpose: behavioural config-port target facing the controller
// Assumes: open-drain lines resolved with pull-ups in the bench
// Notes:   busy time shortened; mute_i makes the target absent
`timescale 1ns/1ps
`default_nettype none
module ccp_dev_model #(
  parameter [6:0] ADDR    = 7'h6a,
  parameter [7:0] IDENTIFICATION_BYTE = 8'h5c,  // arbitrary value
  parameter int   BUSY_NS = 30000
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic mute_i,
  output var  logic sda_oe_o
);
  logic [7:0] regs [256];
  logic [7:0] nvm  [256];
  logic [7:0] sh, ptr;
  logic [1:0] pend, op;
  logic       busy, sel, tx, rdm;
  int         bc, nb;
  initial begin
    for (int i = 0; i < 256; i++) begin
      nvm[i] = i[7:0] ^ 8'ha5;
      regs[i] = 8'h00;
    end
    sda_oe_o = 1'b0;
    sel = 1'b0;
    busy = 1'b0;
    op = 2'h2;
    #1 busy = 1'b1;
  end
  always @(posedge busy) begin
    #(BUSY_NS);
    for (int i = 0; i < 256; i++)
      if (op == 2'h1) nvm[i] = regs[i];
      else regs[i] = nvm[i];
    busy = 1'b0;
  end
  always @(negedge sda_i) if (scl_i) begin
    sel = 1'b1;
    tx = 1'b0;
    rdm = 1'b0;
    bc = -1;
    nb = 0;
    pend = 2'h0;
  end
  always @(posedge sda_i) if (scl_i) begin
    if (sel && (pend == 2'h1 || pend == 2'h2)) begin
      op = pend;
      busy = 1'b1;
    end
    sel = 1'b0;
  end
  always @(posedge scl_i) if (sel && bc >= 0) begin
    if (bc < 8 && !tx) sh = {sh[6:0], sda_i};
    if (bc == 8 && tx && sda_i) sel = 1'b0;
  end
  always @(negedge scl_i) if (sel) begin
    if (bc < 7) begin
      bc++;
      if (tx && bc > 0) sda_oe_o = !sh[7 - bc];
    end else if (bc == 7) begin
      bc = 8;
      sda_oe_o = !tx;
      if (!tx) begin
        if (nb == 0) begin
          sel = !mute_i && !busy && sh[7:1] == ADDR;
          rdm = sh[0];
          sda_oe_o = sel;
        end else if (nb == 1) pend = sh[1:0];
        else if (nb == 2) ptr = sh;
        else begin
          regs[ptr] = sh;
          ptr++;
        end
        nb++;
      end
    end else begin
      bc = 0;
      sda_oe_o = 1'b0;
      if (rdm) begin
        sh = tx ? regs[ptr] : IDENTIFICATION_BYTE;
        if (tx) ptr++;
        tx = 1'b1;
        sda_oe_o = !sh[7];
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the config-port bus controller
// Assumes: 40 MHz clock, pull-ups on both lines
// Notes:   retry count and target busy time shortened
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int DLY = 1;
  localparam [7:0] ID = 8'h5c;
  logic       ref_clk_i = 0, reset_i = 1, req_valid_i = 0, mute = 0;
  logic       req_set_ptr_i = 0, wr_valid_i = 0;
  logic [1:0] req_kind_i = 0;
  logic [7:0] req_ptr_i = 0, req_len_i = 0, wr_data_i = 0;
  wire        req_ready_o, wr_ready_o, rd_valid_o, rd_id_o, busy_o;
  wire        done_o, error_o, scl_o, scl_oe_o, sda_o, sda_oe_o, dev_oe;
  wire  [7:0] rd_data_o;
  wire        scl = !scl_oe_o;
  wire        sda = !(sda_oe_o || dev_oe);
  int         bad_count = 0, samples_checked = 0;
  logic [7:0] wq[$], rq[$];
  logic       idq[$];
  ccp_host #(.RETRY_MAX(8'h03)) u_ccp_host (.ref_clk_i, .reset_i,
    .req_valid_i, .req_kind_i, .req_ptr_i, .req_set_ptr_i, .req_len_i,
    .wr_valid_i, .wr_data_i, .scl_i(scl), .sda_i(sda), .req_ready_o,
    .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_id_o, .busy_o, .done_o,
    .error_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);
  ccp_dev_model #(.IDENTIFICATION_BYTE(ID)) u_ccp_dev_model (.scl_i(scl),
    .sda_i(sda), .mute_i(mute), .sda_oe_o(dev_oe));
  always #12.5 ref_clk_i = !ref_clk_i;
  function automatic logic [7:0] rg(input logic [7:0] a);
    return u_ccp_dev_model.regs[a];
  endfunction
  function automatic logic [7:0] nv(input logic [7:0] a);
    return u_ccp_dev_model.nvm[a];
  endfunction
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic run(input logic [1:0] k, input logic [7:0] p,
                     input logic sp, input logic [7:0] n, input logic e);
    int t;
    logic fin, tk, wr;
    rq.delete();
    idq.delete();
    @(posedge ref_clk_i);
    #DLY;
    {req_valid_i, req_kind_i, req_ptr_i, req_set_ptr_i} = {1'b1, k, p, sp};
    req_len_i = n;
    wr_valid_i = wq.size() > 0;
    if (wr_valid_i) wr_data_i = wq[0];
    t = 0;
    do begin
      @(posedge ref_clk_i);
      t++;
      if (rd_valid_o === 1'b1) begin
        rq.push_back(rd_data_o);
        idq.push_back(rd_id_o);
      end
      fin = done_o === 1'b1;
      tk = req_valid_i && req_ready_o === 1'b1;
      wr = wr_ready_o === 1'b1 && wq.size() > 0;
      #DLY;
      if (tk) req_valid_i = 0;
      if (wr) void'(wq.pop_front());
      wr_valid_i = wq.size() > 0;
      if (wr_valid_i) wr_data_i = wq[0];
    end while (!fin && t < 40000);
    check(fin, "request never finished");
    check(error_o === e, "error flag wrong");
    wq.delete();
    wr_valid_i = 0;
  endtask
  task automatic t_write_wrap();
    wq = '{8'h11, 8'h22, 8'h33, 8'h44};
    run(2'h0, 8'hfe, 0, 8'd4, 0);
    check(rg(8'hfe) === 8'h11 && rg(8'hff) === 8'h22, "burst head");
    check(rg(8'h00) === 8'h33 && rg(8'h01) === 8'h44, "burst wrap");
    check(rg(8'h02) === (8'h02 ^ 8'ha5), "power-up restore");
    $display("test write_wrap done");
  endtask
  task automatic t_read_ptr();
    run(2'h1, 8'hfe, 1, 8'd3, 0);
    check(rq.size() == 4 && idq[0] === 1'b1, "id first");
    check(rq[0] === ID && idq[1] === 1'b0, "identification_byte");
    check(rq[1] === 8'h11 && rq[3] === 8'h33, "read data");
    run(2'h1, 8'h00, 0, 8'd2, 0);
    check(rq.size() == 3 && rq[1] === 8'h44, "continued read");
    check(rq[2] === (8'h02 ^ 8'ha5), "continued second");
    run(2'h1, 8'h00, 0, 8'd0, 0);
    check(rq.size() == 1 && rq[0] === ID, "id only read");
    check(u_ccp_dev_model.ptr === 8'h03, "id only byte not acked");
    $display("test read_ptr done");
  endtask
  task automatic t_save_restore();
    wq = '{8'h5a};
    run(2'h0, 8'h10, 0, 8'd1, 0);
    run(2'h2, 8'h00, 0, 8'd0, 0);
    wq = '{8'h66};
    run(2'h0, 8'h20, 0, 8'd1, 0);
    check(nv(8'h10) === 8'h5a, "save copy");
    check(nv(8'h20) === (8'h20 ^ 8'ha5), "write held off");
    check(rg(8'h20) === 8'h66, "write after save");
    run(2'h3, 8'h00, 0, 8'd0, 0);
    run(2'h1, 8'h20, 1, 8'd1, 0);
    check(rq.size() == 2 && rq[1] === (8'h20 ^ 8'ha5), "restore");
    $display("test save_restore done");
  endtask
  task automatic t_absent();
    mute = 1;
    wq = '{8'h77};
    run(2'h0, 8'h30, 0, 8'd1, 1);
    check(rg(8'h30) === (8'h30 ^ 8'ha5), "absent target");
    mute = 0;
    $display("test absent done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #DLY;
    reset_i = 0;
    t_write_wrap();
    t_read_ptr();
    t_save_restore();
    t_absent();
    tally_and_finish();
  end
  initial begin
    #2000000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
